/* lic_channel_ctrl.v */
/*
  Per-channel line interface control: control register zero and the
  eight pulse segment registers for four channels, pattern routing,
  receiver power gating and equalizer decode.
  The address nibble above the register offset picks the channel.
  Assumes an Avalon-MM master with byte addresses and 8-bit data.
*/
`timescale 1ns/1ps
`include "lic_map.vh"
module lic_channel_ctrl (
  // Clock and reset
  clk,
  rst_n,
  // Avalon-MM slave
  address,
  read,
  write,
  writedata,
  readdata,
  waitrequest,
  response,
  // Pattern enable per channel
  patternEnable,
  // Transmit line per channel
  txData,
  transmitLineTip,
  transmitLineRing,
  transmitAmplitude,
  // Receive line per channel
  receiveLineTip,
  receiveLineRing,
  receivePositiveDataOut,
  receiveClockOut,
  recoveredClock,
  // Status per channel
  receiverPowerOn,
  longHaul,
  shortHaul15dB,
  arbitraryPulse
);
  input  wire        clk;
  input  wire        rst_n;
  input  wire [15:0] address;
  input  wire        read;
  input  wire        write;
  input  wire [7:0]  writedata;
  output reg  [7:0]  readdata;
  output wire        waitrequest;
  output reg  [1:0]  response;
  input  wire [3:0]  patternEnable;
  input  wire [3:0]  txData;
  output reg  [3:0]  transmitLineTip;
  output reg  [3:0]  transmitLineRing;
  output reg  [31:0] transmitAmplitude;
  input  wire [3:0]  receiveLineTip;
  input  wire [3:0]  receiveLineRing;
  output reg  [3:0]  receivePositiveDataOut;
  output reg  [3:0]  receiveClockOut;
  input  wire [3:0]  recoveredClock;
  output wire [3:0]  receiverPowerOn;
  output wire [3:0]  longHaul;
  output wire [3:0]  shortHaul15dB;
  output wire [3:0]  arbitraryPulse;

  // Register storage and bus state
  reg  [7:0]  ctrl_reg [0:3];     // Control register zero per channel
  reg  [7:0]  seg_reg  [0:31];    // Pulse segments, channel*8 + segment
  reg         ack_reg;            // One wait cycle, then acknowledge
  reg  [2:0]  phase_reg [0:3];    // Segment index stepped every clock
  // Decode and datapath nets
  wire [3:0]  patBit;             // Generator outputs
  wire [1:0]  chSel;              // Addressed channel
  wire        hitCtrl;            // Control register hit
  wire        hitSeg;             // Segment register hit
  wire [4:0]  segIdx;             // Flat segment index
  integer     i;                  // Loop index, bus process
  integer     j;                  // Loop index, line output process

  // Channel number sits in the address nibble above the register offset
  assign chSel   = address[5:4];
  // Full 16-bit compare with the channel field blanked; channel numbers 4 to 15
  // keep their high bits and so fall through to the error answer
  assign hitCtrl = ({address[15:6], 2'h0, address[3:0]} == `LIC_CCR0_BASE);
  assign hitSeg  = ({address[15:6], 2'h0, address[3], 3'h0} == `LIC_SEG_BASE);
  assign segIdx  = {chSel, address[2:0]};
  // Hazard: waitrequest is combinational from read and write, never loop it back
  // Every access waits exactly one cycle; keeps read data registered
  assign waitrequest = (read | write) & ~ack_reg;

  // Bus handshake and register writes
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg  <= 1'b0;
      readdata <= 8'h00;
      response <= 2'h0;
      for (i = 0; i < `LIC_NUM_CH; i = i + 1) begin
        ctrl_reg[i]  <= `LIC_CCR0_RESET;
        phase_reg[i] <= 3'h0;
      end
      for (i = 0; i < 32; i = i + 1) begin
        seg_reg[i] <= `LIC_SEG_RESET;
      end
    end else begin
      ack_reg <= (read | write) & ~ack_reg;
      if ((read | write) & ~ack_reg) begin
        // Decode and answer on the wait cycle so data stand at the release edge
        if (hitCtrl) begin
          response <= 2'h0;
          readdata <= ctrl_reg[chSel];
        end else if (hitSeg) begin
          response <= 2'h0;
          readdata <= seg_reg[segIdx];
        end else begin
          // Unmapped: slave error, reads zero, write dropped
          response <= 2'h2;
          readdata <= 8'h00;
        end
      end
      // Write lands at the accepting edge only, when waitrequest is low;
      // committing on the wait cycle would act on a request not yet taken
      if (write & ack_reg) begin
        if (hitCtrl) begin
          ctrl_reg[chSel] <= writedata;
        end else if (hitSeg) begin
          seg_reg[segIdx] <= writedata;
        end
      end
      // Phase counters never stop; they only pace segments and the routed clock
      // Step through the eight pulse segments continuously
      for (i = 0; i < `LIC_NUM_CH; i = i + 1) begin
        phase_reg[i] <= phase_reg[i] + 3'h1;
      end
    end
  end

  // Status decode is combinational from the stored code, so it follows
  // a write from the cycle after the accepting edge
  // One pattern generator per channel
  genvar g;
  generate
    for (g = 0; g < `LIC_NUM_CH; g = g + 1) begin : genCh
      lic_pattern_gen uGen (
        .clk        (clk),
        .rst_n      (rst_n),
        .enable     (patternEnable[g]),
        .useQuasi   (ctrl_reg[g][`LIC_PATTERN_BIT]),
        .patternBit (patBit[g])
      );
      wire [4:0] eqc = ctrl_reg[g][`LIC_EQC_MSB:`LIC_EQC_LSB];
      // Haul class and arbitrary decode from the equalizer code; receiver power from its own bit
      assign longHaul[g]        = (eqc <= `LIC_EQC_LH_LAST) ||
                                  (eqc >= `LIC_EQC_E1_FIRST && eqc[2:1] != 2'h2 && eqc[2:1] != 2'h3);
      assign shortHaul15dB[g]   = (eqc >= `LIC_EQC_SH_FIRST && eqc <= `LIC_EQC_T1_ARB) ||
                                  eqc[4:1] == 4'hE;
      assign arbitraryPulse[g]  = (eqc == `LIC_EQC_T1_ARB) || (eqc == `LIC_EQC_T1G_ARB);
      assign receiverPowerOn[g] = ctrl_reg[g][`LIC_RXON_BIT];
    end
  endgenerate

  // Registered line outputs: routing, receive gating and amplitude
  // Limitation: segment phase runs free, not aligned to any bit boundary
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      transmitLineTip        <= 4'h0;
      transmitLineRing       <= 4'h0;
      receivePositiveDataOut <= 4'h0;
      receiveClockOut        <= 4'h0;
      transmitAmplitude      <= 32'h00000000;
    end else begin
      for (j = 0; j < `LIC_NUM_CH; j = j + 1) begin
        if (patternEnable[j] && !ctrl_reg[j][`LIC_ROUTE_BIT]) begin
          // Pattern replaces transmit data on the pair
          transmitLineTip[j]  <= patBit[j];
          transmitLineRing[j] <= ~patBit[j];
        end else begin
          transmitLineTip[j]  <= txData[j];
          transmitLineRing[j] <= ~txData[j];
        end
        if (patternEnable[j] && ctrl_reg[j][`LIC_ROUTE_BIT]) begin
          // Pattern shown on the receive outputs instead
          receivePositiveDataOut[j] <= patBit[j];
          receiveClockOut[j]        <= clk_phase(phase_reg[j]);
        end else if (ctrl_reg[j][`LIC_RXON_BIT]) begin
          // Powered receiver passes line data; off means quiet outputs
          receivePositiveDataOut[j] <= receiveLineTip[j] & ~receiveLineRing[j];
          receiveClockOut[j]        <= recoveredClock[j];
        end else begin
          receivePositiveDataOut[j] <= 1'b0;
          receiveClockOut[j]        <= 1'b0;
        end
        // Arbitrary mode: amplitude follows programmed segments
        if (arbitraryPulse[j]) begin
          transmitAmplitude[j*8 +: 8] <= seg_reg[{j[1:0], phase_reg[j]}];
        end else begin
          transmitAmplitude[j*8 +: 8] <= {3'h0, ctrl_reg[j][`LIC_EQC_MSB:`LIC_EQC_LSB]};
        end
      end
    end
  end

  // Routed clock is a divide-by-eight of the core clock, not a line clock
  // Clock for routed pattern: high in first half of segment cycle
  function clk_phase;
    input [2:0] ph;
    begin
      clk_phase = ~ph[2];
    end
  endfunction
endmodule

/* lic_map.vh */
/*
  Register map constants for the line interface channel control block.
  Assumes inclusion by bare name from the design files of this folder.
*/
`ifndef LIC_MAP_VH
`define LIC_MAP_VH
// Byte address of control register zero, channel 0; channel fills bits 7:4
`define LIC_CCR0_BASE      16'h0F00
// Byte address of first pulse segment register, channel 0 (segments at +8..+F)
`define LIC_SEG_BASE       16'h0F08
// Channel count
`define LIC_NUM_CH         4
// Field positions of control register zero
`define LIC_PATTERN_BIT    7
`define LIC_ROUTE_BIT      6
`define LIC_RXON_BIT       5
`define LIC_EQC_MSB        4
`define LIC_EQC_LSB        0
// Reset values
`define LIC_CCR0_RESET     8'h00
`define LIC_SEG_RESET      8'h00
// Pattern generator seed, non-zero so the shift register never locks up
`define LIC_PATTERN_SEED   20'h00001
// Equalizer code ranges
`define LIC_EQC_SH_FIRST   5'h08
`define LIC_EQC_SH_LAST    5'h0C
`define LIC_EQC_T1_ARB     5'h0D
`define LIC_EQC_T1G_ARB    5'h13
`define LIC_EQC_LH_LAST    5'h07
`define LIC_EQC_GAIN_LO    5'h0E
`define LIC_EQC_GAIN_HI    5'h17
`define LIC_EQC_E1_FIRST   5'h18
// Pattern generator feedback taps
`define LIC_PRBS_TAP_A     15
`define LIC_PRBS_TAP_B     14
`define LIC_QRSS_TAP_A     20
`define LIC_QRSS_TAP_B     17
`endif

/* lic_pattern_gen.v */
/*
  One channel's test pattern generator: 2^15-1 pseudo-random or 2^20-1
  quasi-random sequence, one bit per clock.
  Assumes the owner holds it enabled only while a pattern is wanted.
*/
`timescale 1ns/1ps
`include "lic_map.vh"
module lic_pattern_gen (
  // Clock and reset
  clk,
  rst_n,
  // Control
  enable,
  useQuasi,
  // Pattern bit
  patternBit
);
  input  wire clk;
  input  wire rst_n;
  input  wire enable;
  input  wire useQuasi;
  output wire patternBit;

  reg  [19:0] shift_reg;  // Shared shift register, low 15 bits for short mode
  reg  [19:0] shift_next;
  reg         fbBit;       // Feedback tap sum

  // Feedback picks the taps of the chosen polynomial
  always @* begin
    if (useQuasi) begin
      fbBit = shift_reg[`LIC_QRSS_TAP_A-1] ^ shift_reg[`LIC_QRSS_TAP_B-1];
    end else begin
      fbBit = shift_reg[`LIC_PRBS_TAP_A-1] ^ shift_reg[`LIC_PRBS_TAP_B-1];
    end
    shift_next = {shift_reg[18:0], fbBit};
  end

  // Seed is non-zero so the sequence never locks up
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= `LIC_PATTERN_SEED;
    end else if (enable) begin
      shift_reg <= shift_next;
    end
  end

  // Quasi-random output forces a one after long zero runs, as usual for this pattern
  assign patternBit = useQuasi ? (fbBit | ~(|shift_reg[13:0])) : fbBit;
endmodule

/* lic_channel_ctrl_chk.sv */
/* Port checker for lic_channel_ctrl.
   Assumes the bind below and channel 0 traffic. */
`timescale 1ns/1ps
module lic_chk (
  // Clock, reset and bus
  input wire logic        clk, rst_n, read, write, waitrequest,
  input wire logic [15:0] address,
  input wire logic [7:0]  writedata, readdata,
  input wire logic [1:0]  response,
  // Line side and status
  input wire logic [3:0]  patternEnable, txData, transmitLineTip, transmitLineRing,
  input wire logic [3:0]  receiverPowerOn, longHaul, shortHaul15dB, receivePositiveDataOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Accepted write to channel 0 control
  wire w0 = write && !waitrequest && address == 16'h0F00;
  AST_WAIT_FIRST: assert property ($rose(read || write) |-> waitrequest)
    else $error("No wait cycle");
  AST_ONE_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("Wait too long");
  AST_UNMAPPED: assert property (read && !waitrequest && address == 16'h0100
    |-> response == 2'b10 && readdata == 8'h00) else $error("Unmapped read");
  AST_RXON: assert property (w0 |=> receiverPowerOn[0] == $past(writedata[5]))
    else $error("Receiver power");
  AST_LONG: assert property (w0 && writedata[4:0] <= 5'h07 |=> longHaul[0])
    else $error("Long haul");
  AST_SHORT: assert property (w0 && writedata[4:0] inside {[5'h08:5'h0C]}
    |=> shortHaul15dB[0] && !longHaul[0]) else $error("Short haul");
  // Quiet generator leaves normal data on the pair
  AST_TXPASS: assert property ($past(rst_n) && !patternEnable[0] ##1 !patternEnable[0]
    |-> transmitLineTip[0] == $past(txData[0])) else $error("Tx data");
  AST_RING: assert property ($past(rst_n) |-> transmitLineRing == ~transmitLineTip)
    else $error("Ring not inverse");
  AST_RXOFF: assert property ($past(rst_n) && !receiverPowerOn[0] && !patternEnable[0]
    ##1 !patternEnable[0] |-> !receivePositiveDataOut[0]) else $error("Rx not off");
  cover property (w0);
  cover property (read && !waitrequest && response == 2'b10);
  cover property (patternEnable[0] && receivePositiveDataOut[0]);
endmodule
bind lic_channel_ctrl lic_chk chk_u (.*);

/* lic_line_model.sv */
/* Line partner: drives a changing receive pair.
   Assumes one clock shared with the design. */
`timescale 1ns/1ps
module lic_line_model (
  // Clock and reset
  input  wire logic       clk, rst_n,
  // Transmit pair, observed only
  input  wire logic [3:0] transmitLineTip, transmitLineRing,
  // Receive pair and clock
  output logic      [3:0] receiveLineTip, receiveLineRing, recoveredClock
);
  logic [3:0] lineCnt_reg;  // Counter so each channel sees its own rate
  // Free counter; never parks, so stale data cannot pass
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) lineCnt_reg <= 4'h0;
    else lineCnt_reg <= lineCnt_reg + 4'h1;
  end
  // Incoming stream, ring the inverse of tip
  assign receiveLineTip  = {lineCnt_reg[3:1], ~lineCnt_reg[0]};
  assign receiveLineRing = ~receiveLineTip;
  assign recoveredClock  = {4{lineCnt_reg[0]}};
endmodule

/* lic_channel_ctrl_tb.sv */
/* Testbench for lic_channel_ctrl.
   Assumes lic_line_model and the bound checker. */
`timescale 1ns/1ps
`include "lic_map.vh"
module lic_channel_ctrl_tb;
  logic clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0;
  logic [15:0] address = 16'h0000;   // Bus address
  logic [7:0]  writedata = 8'h00, rdData;
  logic [3:0]  patternEnable = 4'h0, txData = 4'h0;
  logic [31:0] capA, capB;           // Captured pattern words
  logic        clkSeen;              // Expected next receive clock level
  wire  [7:0]  readdata;
  wire         waitrequest;
  wire  [1:0]  response;
  wire  [3:0]  transmitLineTip, transmitLineRing, receivePositiveDataOut, receiveClockOut;
  wire  [3:0]  receiveLineTip, receiveLineRing, recoveredClock;
  wire  [3:0]  receiverPowerOn, longHaul, shortHaul15dB, arbitraryPulse;
  wire  [31:0] transmitAmplitude;
  int error_cnt = 0, samples_checked = 0, cycleCnt = 0;
  localparam logic [7:0] VALS [4] = '{8'h29, 8'h03, 8'h2C, 8'h0D};
  always #2 clk = ~clk;
  lic_channel_ctrl dut_u (.*);
  lic_line_model line_u (.*);
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Bus cycle: raise after an edge, hold until waitrequest is low at an edge
  task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rdData = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // Short pattern recurrence from the package taps, over captured bits only
  function automatic logic prbs_ok(input logic [31:0] v);
    prbs_ok = 1'b1;
    for (int k = 0; k < 15; k++)
      if (v[k] !== (v[k + `LIC_PRBS_TAP_A] ^ v[k + `LIC_PRBS_TAP_B])) prbs_ok = 1'b0;
  endfunction
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string nm);
    acc(1'b0, a, 8'h00);
    chk(nm, rdData, e);
  endtask
  // Shift in 32 line bits of channel 0
  task automatic cap(input logic tx, output logic [31:0] v);
    repeat (32) begin
      @(negedge clk);
      v = {v[30:0], tx ? transmitLineTip[0] : receivePositiveDataOut[0]};
    end
  endtask
  task automatic give_verdict;
    $display("Checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard, far above the run length
  always @(posedge clk) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int n = 0; n < 4; n++) rd(16'h0F00 + 16'(n * 16), 8'h00, "ctrl reset");
    rd(16'h0F0F, 8'h00, "seg reset");
    chk("rx power", receiverPowerOn, 4'h0);
    acc(1'b1, 16'h0F00, 8'h05);
    @(negedge clk);
    chk("long haul all", longHaul, 4'hF);
    for (int n = 0; n < 4; n++) acc(1'b1, 16'h0F00 + 16'(n * 16), VALS[n]);
    for (int k = 0; k < 8; k++) acc(1'b1, 16'h0F38 + 16'(k), 8'h5A);
    acc(1'b1, 16'h0F40, 8'hFF);  // Unmapped write, must be dropped
    for (int n = 0; n < 4; n++) rd(16'h0F00 + 16'(n * 16), VALS[n], "ctrl copy");
    chk("ok resp", response, 2'b00);
    rd(16'h0100, 8'h00, "unmapped data");
    chk("unmapped resp", response, 2'b10);
    chk("rx power", receiverPowerOn, 4'h5);
    chk("long haul", longHaul, 4'h2);
    chk("short haul", shortHaul15dB, 4'hD);
    chk("arbitrary", arbitraryPulse, 4'h8);
    chk("amplitude", transmitAmplitude, 32'h5A0C0309);
    txData <= 4'hA;
    repeat (3) @(negedge clk);
    chk("tx tip", transmitLineTip, 4'hA);
    chk("tx ring", transmitLineRing, 4'h5);
    // Receiver on passes the line clock and data; off channels stay quiet
    clkSeen = ~receiveClockOut[0];
    @(negedge clk);
    chk("rx clock", receiveClockOut[0], clkSeen);
    chk("rx data", receivePositiveDataOut[0] ^ receiveClockOut[0], 1'b1);
    chk("rx off", {receiveClockOut & 4'hA, receivePositiveDataOut & 4'hA}, 8'h00);
    // Route to receive side, then switch pattern kind
    acc(1'b1, 16'h0F00, 8'h69);
    patternEnable <= 4'h1;
    cap(1'b0, capA);
    acc(1'b1, 16'h0F00, 8'hE9);
    cap(1'b0, capB);
    chk("rx pattern", 32'(capA != 32'h0 && capA != 32'hFFFFFFFF), 32'h1);
    chk("rx prbs", 32'(prbs_ok(capA)), 32'h1);
    chk("kind differs", 32'(capA != capB), 32'h1);
    chk("quasi kind", 32'(prbs_ok(capB)), 32'h0);
    acc(1'b1, 16'h0F00, 8'h29);
    cap(1'b1, capA);
    chk("tx pattern", 32'(capA != 32'h0 && capA != 32'hFFFFFFFF), 32'h1);
    chk("tx prbs", 32'(prbs_ok(capA)), 32'h1);
    give_verdict();
  end
endmodule
